// ==== include/undertemp_vin_ov_limit_regs.vh ====
`ifndef UNDERTEMP_VIN_OV_LIMIT_REGS_VH
`define UNDERTEMP_VIN_OV_LIMIT_REGS_VH

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define CODE_WARN_THRESH     8'h52
`define CODE_FAULT_THRESH    8'h53
`define CODE_UT_FAULT_ACTION 8'h54
`define CODE_VIN_OV_LIMIT    8'h55

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_WARN_THRESH      16'hdc40
`define RST_FAULT_THRESH     16'he530
`define RST_UT_FAULT_ACTION  8'hbf
`define RST_VIN_OV_LIMIT     16'hd380

// ----------------------------------------------------------------
// Action field positions and codes
// ----------------------------------------------------------------
`define ACT_MODE_HI          7
`define ACT_MODE_LO          6
`define ACT_RETRY_HI         5
`define ACT_RETRY_LO         3
`define ACT_DELAY_HI         2
`define ACT_DELAY_LO         0
`define MODE_DISABLE_RETRY   2'h2
`define MODE_DISABLE_HOLD    2'h3
`define RETRY_NONE           3'h0
`define RETRY_CONTINUOUS     3'h7

// ----------------------------------------------------------------
// Linear format fields
// ----------------------------------------------------------------
`define LIN_EXP_HI           15
`define LIN_EXP_LO           11
`define LIN_MANT_HI          10
`define LIN_MANT_LO          0
`define LIN_FRAC_BITS        4

// ----------------------------------------------------------------
// Accepted ranges, in 1/16 units
// ----------------------------------------------------------------
`define UT_RANGE_MIN         (-55 * 16)
`define UT_RANGE_MAX         (25 * 16)
`define VIN_RANGE_MIN        (0 * 16)
`define VIN_RANGE_MAX        (19 * 16)

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_KHZ              40000
`define RETRY_UNIT_MS        35
`define RETRY_UNIT_CYC       (`RETRY_UNIT_MS * `CLK_KHZ)

`endif

// ==== logic/undertemp_vin_ov_limit_regs.v ====
`timescale 1ns/10ps
`default_nettype none
`include "undertemp_vin_ov_limit_regs.vh"

// What this block does
// RULE1 - Below warning limit: summary, warning flag, alert
// RULE2 - Paged 16-bit warning limit, reset -30C, range-checked
// RULE3 - Paged 16-bit linear under-temperature fault limit
// RULE4 - Fault limit resets -45C, accepts -55..+25C
// RULE5 - Paged 8-bit fault action, reset continuous retry
// RULE6 - Fault pulls alert low, flag until clear
// RULE7 - Mode 10 disables, then retry per bits 5:3
// RULE8 - Mode 11 holds off until above warning
// RULE9 - Retry 000: stay off until restart
// RULE10 - Retry 111: retry until commanded off or fault
// RULE11 - Retry only after rising above warning limit
// RULE12 - Retry spacing is (delay+1) times 35 ms
// RULE13 - Global 16-bit input over-voltage fault limit, 0..19V
// RULE14 - Over-voltage limit resets to 14 volts
// RULE15 - Over-voltage limit global, others per page
// RULE16 - Linear values: 5-bit exponent, 11-bit mantissa
// RULE17 - Below fault limit declares fault, runs action
module undertemp_vin_ov_limit_regs #(
	parameter RETRY_UNIT_CYC = `RETRY_UNIT_CYC
) (
	// Clock and reset
	input  wire        clock_i,
	input  wire        rst_i,
	// Command port
	input  wire        cmd_wr_i,
	input  wire        cmd_rd_i,
	input  wire [7:0]  cmd_code_i,
	input  wire [15:0] cmd_data_i,
	input  wire        page_i,
	output wire [15:0] rd_data_o,
	output wire        rd_valid_o,
	output wire        cmd_reject_o,
	input  wire        clear_faults_i,
	// Measurement and control
	input  wire [31:0] temp_i,
	input  wire        en_pin_i,
	input  wire        operation_on_i,
	input  wire        other_fault_i,
	// Status and output control
	output wire [1:0]  out_enable_o,
	output wire [1:0]  ut_warning_o,
	output wire [1:0]  ut_fault_o,
	output wire        temp_summary_o,
	output wire        host_alert_line_o,
	output wire        host_alert_line_oe_o
);

	localparam PAGES     = 2;
	localparam ST_RUN    = 3'h0;
	localparam ST_LATCH  = 3'h1;
	localparam ST_HOLD   = 3'h2;
	localparam ST_WARM   = 3'h3;
	localparam ST_DELAY  = 3'h4;

	// ----------------------------------------------------------------
	// Linear format decode to 1/16 units
	// ----------------------------------------------------------------
	function signed [31:0] lin_to_q4;
		input [15:0] lin;
		reg signed [31:0] mant;
		reg signed [5:0]  sh;
		begin
			mant = {{21{lin[`LIN_MANT_HI]}}, lin[`LIN_MANT_HI:`LIN_MANT_LO]}; // RULE16
			sh = $signed({lin[`LIN_EXP_HI], lin[`LIN_EXP_HI:`LIN_EXP_LO]}) + 6'sh4; // RULE16
			if (sh >= 0) begin
				lin_to_q4 = mant <<< sh; // RULE16
			end else begin
				lin_to_q4 = mant >>> (-sh); // RULE16
			end
		end
	endfunction

	// ----------------------------------------------------------------
	// Enable pin synchroniser
	// ----------------------------------------------------------------
	reg en_meta_ff;
	reg en_sync_ff;
	always @(posedge clock_i) begin
		if (rst_i) begin
			en_meta_ff <= 1'b0;
			en_sync_ff <= 1'b0;
		end else begin
			en_meta_ff <= en_pin_i;
			en_sync_ff <= en_meta_ff;
		end
	end

	wire cmd_on = en_sync_ff & operation_on_i;
	wire abort  = ~cmd_on | other_fault_i;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	reg  [31:0] warn_ff;
	reg  [31:0] fault_lim_ff;
	reg  [15:0] action_ff;
	reg  [15:0] vin_ov_ff;
	reg  [15:0] rd_data_ff;
	reg         rd_valid_ff;
	reg         reject_ff;
	wire signed [31:0] wr_val = lin_to_q4(cmd_data_i);
	wire        ut_ok  = (wr_val >= `UT_RANGE_MIN) && (wr_val <= `UT_RANGE_MAX);
	wire        vin_ok = (wr_val >= `VIN_RANGE_MIN) && (wr_val <= `VIN_RANGE_MAX);
	wire [4:0]  pg_lo  = page_i ? 5'h10 : 5'h00;
	wire [3:0]  pa_lo  = page_i ? 4'h8 : 4'h0;
	integer     i;

	always @(posedge clock_i) begin
		if (rst_i) begin
			for (i = 0; i < PAGES; i = i + 1) begin
				warn_ff[i*16 +: 16]      <= `RST_WARN_THRESH; // RULE2
				fault_lim_ff[i*16 +: 16] <= `RST_FAULT_THRESH; // RULE4
				action_ff[i*8 +: 8]      <= `RST_UT_FAULT_ACTION; // RULE5
			end
			vin_ov_ff   <= `RST_VIN_OV_LIMIT; // RULE14
			rd_data_ff  <= 16'h0000;
			rd_valid_ff <= 1'b0;
			reject_ff   <= 1'b0;
		end else begin
			reject_ff   <= 1'b0;
			rd_valid_ff <= cmd_rd_i;
			if (cmd_wr_i) begin
				case (cmd_code_i)
				`CODE_WARN_THRESH: begin
					if (ut_ok) begin
						warn_ff[pg_lo +: 16] <= cmd_data_i; // RULE2 RULE15
					end else begin
						reject_ff <= 1'b1; // RULE2
					end
				end
				`CODE_FAULT_THRESH: begin
					if (ut_ok) begin
						fault_lim_ff[pg_lo +: 16] <= cmd_data_i; // RULE3 RULE15
					end else begin
						reject_ff <= 1'b1; // RULE4
					end
				end
				`CODE_UT_FAULT_ACTION: begin
					action_ff[pa_lo +: 8] <= cmd_data_i[7:0]; // RULE5 RULE15
				end
				`CODE_VIN_OV_LIMIT: begin
					if (vin_ok) begin
						vin_ov_ff <= cmd_data_i; // RULE13 RULE15
					end else begin
						reject_ff <= 1'b1; // RULE13
					end
				end
				default: begin
					reject_ff <= 1'b1;
				end
				endcase
			end
			if (cmd_rd_i) begin
				case (cmd_code_i)
				`CODE_WARN_THRESH:     rd_data_ff <= warn_ff[pg_lo +: 16];
				`CODE_FAULT_THRESH:    rd_data_ff <= fault_lim_ff[pg_lo +: 16];
				`CODE_UT_FAULT_ACTION: rd_data_ff <= {8'h00, action_ff[pa_lo +: 8]};
				`CODE_VIN_OV_LIMIT:    rd_data_ff <= vin_ov_ff;
				default: begin
					rd_data_ff <= 16'h0000;
					reject_ff  <= 1'b1;
				end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Per-page supervision
	// ----------------------------------------------------------------
	wire [1:0] warn_flag_w;
	wire [1:0] fault_flag_w;
	wire [1:0] en_w;

	genvar g;
	generate
		for (g = 0; g < PAGES; g = g + 1) begin : gen_page
			reg  [2:0]  st_ff;
			reg  [2:0]  nxt_st;
			reg  [2:0]  cnt_ff;
			reg  [2:0]  nxt_cnt;
			reg  [31:0] pre_ff;
			reg         en_ff;
			reg         warn_flag_ff;
			reg         fault_flag_ff;
			wire [7:0]  act    = action_ff[g*8 +: 8];
			wire [1:0]  mode   = act[`ACT_MODE_HI:`ACT_MODE_LO];
			wire [2:0]  retry  = act[`ACT_RETRY_HI:`ACT_RETRY_LO];
			wire [2:0]  delay  = act[`ACT_DELAY_HI:`ACT_DELAY_LO];
			wire signed [31:0] t_val = lin_to_q4(temp_i[g*16 +: 16]); // RULE16
			wire signed [31:0] w_val = lin_to_q4(warn_ff[g*16 +: 16]); // RULE16
			wire signed [31:0] f_val = lin_to_q4(fault_lim_ff[g*16 +: 16]); // RULE16
			wire        cold   = t_val < f_val; // RULE17
			wire        chilly = t_val < w_val; // RULE1
			wire        warm   = t_val > w_val; // RULE8 RULE11
			wire        tick   = (pre_ff == RETRY_UNIT_CYC - 1);

			always @* begin
				nxt_st  = st_ff;
				nxt_cnt = cnt_ff;
				case (st_ff)
				ST_RUN: begin
					if (cold && mode == `MODE_DISABLE_RETRY) begin // RULE7 RULE17
						if (retry == `RETRY_CONTINUOUS) begin
							nxt_st = ST_WARM; // RULE10
						end else begin
							nxt_st = ST_LATCH; // RULE9
						end
					end else if (cold && mode == `MODE_DISABLE_HOLD) begin
						nxt_st = ST_HOLD; // RULE8
					end
				end
				ST_LATCH: begin
					nxt_st = ST_LATCH; // RULE9
				end
				ST_HOLD: begin
					if (warm) begin
						nxt_st = ST_RUN; // RULE8
					end
				end
				ST_WARM: begin
					if (abort) begin
						nxt_st = ST_RUN; // RULE10
					end else if (warm) begin
						nxt_st  = ST_DELAY; // RULE11
						nxt_cnt = 3'h0;
					end
				end
				ST_DELAY: begin
					if (abort) begin
						nxt_st = ST_RUN; // RULE10
					end else if (tick) begin
						if (cnt_ff == delay) begin
							nxt_st = ST_RUN; // RULE12
						end else begin
							nxt_cnt = cnt_ff + 3'h1; // RULE12
						end
					end
				end
				default: begin
					nxt_st = ST_RUN;
				end
				endcase
			end

			always @(posedge clock_i) begin
				if (rst_i) begin
					st_ff         <= ST_RUN;
					cnt_ff        <= 3'h0;
					pre_ff        <= 32'h0;
					en_ff         <= 1'b0;
					warn_flag_ff  <= 1'b0;
					fault_flag_ff <= 1'b0;
				end else begin
					st_ff  <= nxt_st;
					cnt_ff <= nxt_cnt;
					if (st_ff != ST_DELAY || tick) begin
						pre_ff <= 32'h0; // RULE12
					end else begin
						pre_ff <= pre_ff + 32'h1; // RULE12
					end
					en_ff <= (nxt_st == ST_RUN) && cmd_on && !other_fault_i; // RULE7 RULE10
					if (chilly) begin
						warn_flag_ff <= 1'b1; // RULE1
					end else if (clear_faults_i) begin
						warn_flag_ff <= 1'b0;
					end
					if (cold) begin
						fault_flag_ff <= 1'b1; // RULE6 RULE17
					end else if (clear_faults_i) begin
						fault_flag_ff <= 1'b0; // RULE6
					end
				end
			end

			assign warn_flag_w[g]  = warn_flag_ff;
			assign fault_flag_w[g] = fault_flag_ff;
			assign en_w[g]         = en_ff;
		end
	endgenerate

	// ----------------------------------------------------------------
	// Summary and alert
	// ----------------------------------------------------------------
	reg summary_ff;
	reg alert_oe_ff;
	reg alert_ff;
	always @(posedge clock_i) begin
		if (rst_i) begin
			summary_ff  <= 1'b0;
			alert_oe_ff <= 1'b0;
			alert_ff    <= 1'b0;
		end else begin
			summary_ff  <= |{warn_flag_w, fault_flag_w}; // RULE1
			alert_oe_ff <= |{warn_flag_w, fault_flag_w}; // RULE1 RULE6
			alert_ff    <= 1'b0;
		end
	end

	assign rd_data_o            = rd_data_ff;
	assign rd_valid_o           = rd_valid_ff;
	assign cmd_reject_o         = reject_ff;
	assign out_enable_o         = en_w;
	assign ut_warning_o         = warn_flag_w;
	assign ut_fault_o           = fault_flag_w;
	assign temp_summary_o       = summary_ff;
	assign host_alert_line_o    = alert_ff;
	assign host_alert_line_oe_o = alert_oe_ff;

endmodule // undertemp_vin_ov_limit_regs

`default_nettype wire

// ==== dv/undertemp_vin_ov_limit_regs_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
module ut_limit_checker #(
	parameter RETRY_UNIT_CYC = 20
) (
	input wire logic        clock_i,
	input wire logic        rst_i,
	input wire logic        cmd_wr_i,
	input wire logic        cmd_rd_i,
	input wire logic [7:0]  cmd_code_i,
	input wire logic        clear_faults_i,
	input wire logic        operation_on_i,
	input wire logic [15:0] rd_data_o,
	input wire logic        rd_valid_o,
	input wire logic        cmd_reject_o,
	input wire logic [1:0]  out_enable_o,
	input wire logic [1:0]  ut_warning_o,
	input wire logic [1:0]  ut_fault_o,
	input wire logic        temp_summary_o,
	input wire logic        host_alert_line_o,
	input wire logic        host_alert_line_oe_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);
	wire logic any_flag = |{ut_warning_o, ut_fault_o};
	wire logic bad_code = cmd_code_i < 8'h52 || cmd_code_i > 8'h55;
	a_read_answer: assert property (cmd_rd_i |=> rd_valid_o)
		else $error("read not answered");
	a_no_stray_valid: assert property (!cmd_rd_i |=> !rd_valid_o)
		else $error("stray read valid");
	a_read_hold: assert property (!cmd_rd_i |=> $stable(rd_data_o))
		else $error("read data moved");
	a_bad_code: assert property ((cmd_wr_i || cmd_rd_i) && bad_code |=> cmd_reject_o)
		else $error("unknown code taken");
	a_reject_cause: assert property (cmd_reject_o |-> $past(cmd_wr_i || cmd_rd_i))
		else $error("reject without request");
	a_summary_tracks: assert property (1'b1 |=> temp_summary_o == $past(any_flag))
		else $error("summary wrong");
	a_alert_drive: assert property (host_alert_line_oe_o == temp_summary_o && !host_alert_line_o)
		else $error("alert line wrong");
	a_fault_sticky: assert property (ut_fault_o[0] && !clear_faults_i |=> ut_fault_o[0])
		else $error("fault flag lost");
	a_warn_sticky: assert property (ut_warning_o[1] && !clear_faults_i |=> ut_warning_o[1])
		else $error("warning flag lost");
	a_command_off: assert property (!operation_on_i |=> out_enable_o == 2'b00)
		else $error("output on while off");
	cover property ($rose(ut_fault_o[0]));
	cover property ($rose(out_enable_o[0]) && !ut_fault_o[0] == 1'b0);
	cover property (cmd_reject_o);
endmodule // ut_limit_checker

bind undertemp_vin_ov_limit_regs ut_limit_checker #(.RETRY_UNIT_CYC(RETRY_UNIT_CYC)) u_chk (
	.clock_i, .rst_i, .cmd_wr_i, .cmd_rd_i, .cmd_code_i, .clear_faults_i, .operation_on_i,
	.rd_data_o, .rd_valid_o, .cmd_reject_o, .out_enable_o, .ut_warning_o, .ut_fault_o,
	.temp_summary_o, .host_alert_line_o, .host_alert_line_oe_o);
`default_nettype wire

// ==== dv/pm_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module pm_host_model (
	input  wire logic        clock_i,
	output var  logic        cmd_wr_o,
	output var  logic        cmd_rd_o,
	output var  logic [7:0]  cmd_code_o,
	output var  logic [15:0] cmd_data_o,
	output var  logic        page_o
);
	initial begin
		cmd_wr_o = 0;
		cmd_rd_o = 0;
		cmd_code_o = 8'h00;
		cmd_data_o = 16'h0000;
		page_o = 0;
	end
	// One-cycle strobe, then released fields are scrambled
	task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d, input logic p);
		@(posedge clock_i);
		#1;
		cmd_wr_o = w;
		cmd_rd_o = !w;
		cmd_code_o = c;
		cmd_data_o = d;
		page_o = p;
		@(posedge clock_i);
		#1;
		cmd_wr_o = 0;
		cmd_rd_o = 0;
		cmd_code_o = ~c;
		cmd_data_o = ~d;
		page_o = ~p;
	endtask
endmodule // pm_host_model
`default_nettype wire

// ==== dv/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "undertemp_vin_ov_limit_regs.vh"
module tb;
	localparam int UNIT = 20;
	logic clock_i = 0, rst_i = 1, clear_faults_i = 0;
	logic en_pin_i = 1, operation_on_i = 1, other_fault_i = 0;
	logic [31:0] temp_i = 32'h0019_0019;
	wire logic cmd_wr_i, cmd_rd_i, page_i, rd_valid_o, cmd_reject_o, temp_summary_o;
	wire logic host_alert_line_o, host_alert_line_oe_o;
	wire logic [7:0] cmd_code_i;
	wire logic [15:0] cmd_data_i, rd_data_o;
	wire logic [1:0] out_enable_o, ut_warning_o, ut_fault_o;
	int mismatches = 0, num_checks = 0, n;
	always #12.5 clock_i = ~clock_i;
	undertemp_vin_ov_limit_regs #(.RETRY_UNIT_CYC(UNIT)) u_undertemp_vin_ov_limit_regs (
		.clock_i, .rst_i, .cmd_wr_i, .cmd_rd_i, .cmd_code_i, .cmd_data_i, .page_i,
		.rd_data_o, .rd_valid_o, .cmd_reject_o, .clear_faults_i, .temp_i, .en_pin_i,
		.operation_on_i, .other_fault_i, .out_enable_o, .ut_warning_o, .ut_fault_o,
		.temp_summary_o, .host_alert_line_o, .host_alert_line_oe_o);
	pm_host_model u_host (.clock_i, .cmd_wr_o(cmd_wr_i), .cmd_rd_o(cmd_rd_i),
		.cmd_code_o(cmd_code_i), .cmd_data_o(cmd_data_i), .page_o(page_i));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clock_i);
		#1;
	endtask
	task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic p, input logic rej);
		u_host.xfer(1, c, d, p);
		chk(cmd_reject_o, rej);
	endtask
	task automatic rd(input logic [7:0] c, input logic p, input logic [15:0] exp);
		u_host.xfer(0, c, 16'h0000, p);
		chk(rd_data_o, exp);
		chk(rd_valid_o, 1);
		chk(cmd_reject_o, c > 8'h55);
	endtask
	task automatic wait_oe(input int p, input logic v, input int lim);
		n = 0;
		while (out_enable_o[p] !== v && n < lim) begin
			cyc(1);
			n++;
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#(25 * 5000);
		mismatches++;
		end_of_test();
	end
	initial begin
		cyc(8);
		rst_i = 0;
		cyc(4);
		for (int p = 0; p < 2; p++) begin
			rd(8'h52, p, `RST_WARN_THRESH);
			rd(8'h53, p, `RST_FAULT_THRESH);
			rd(8'h54, p, {8'h00, `RST_UT_FAULT_ACTION});
			rd(8'h55, p, `RST_VIN_OV_LIMIT);
		end
		rd(8'h56, 0, 16'h0000);
		chk(out_enable_o, 2'b11);
		wr(8'h52, 16'hdc80, 1, 0);
		rd(8'h52, 0, 16'hdc40);
		rd(8'h52, 1, 16'hdc80);
		wr(8'h55, 16'hd3a0, 1, 0);
		rd(8'h55, 0, 16'hd3a0);
		wr(8'h52, 16'hdbc0, 0, 1);
		wr(8'h53, 16'he440, 0, 1);
		wr(8'h55, 16'hda80, 0, 1);
		wr(8'h53, 16'he490, 1, 0);
		rd(8'h53, 0, 16'he530);
		wr(8'h54, 16'h00c0, 1, 0);
		rd(8'h54, 1, 16'h00c0);
		$display("register tests done");
		temp_i[15:0] = 16'he5d0;
		cyc(2);
		chk({ut_warning_o[0], ut_fault_o[0], out_enable_o[0]}, 3'b101);
		chk({temp_summary_o, host_alert_line_oe_o, host_alert_line_o}, 3'b110);
		temp_i[15:0] = 16'h0019;
		cyc(2);
		chk(ut_warning_o[0], 1);
		clear_faults_i = 1;
		cyc(1);
		clear_faults_i = 0;
		cyc(2);
		chk({ut_warning_o, host_alert_line_oe_o}, 3'b000);
		$display("warning test done");
		temp_i[15:0] = 16'he4e0;
		cyc(1);
		chk({ut_fault_o[0], out_enable_o[0]}, 2'b10);
		cyc(60);
		chk(out_enable_o[0], 0);
		temp_i[15:0] = 16'h0019;
		wait_oe(0, 1, 400);
		chk(n >= 8 * UNIT - 1 && n <= 8 * UNIT + 4, 1);
		temp_i[31:16] = 16'he440;
		cyc(2);
		chk(out_enable_o[1], 0);
		temp_i[31:16] = 16'h0019;
		wait_oe(1, 1, 10);
		chk(n <= 3, 1);
		wr(8'h54, 16'h00b8, 0, 0);
		temp_i[15:0] = 16'he4e0;
		cyc(2);
		temp_i[15:0] = 16'h0019;
		wait_oe(0, 1, 400);
		chk(n >= UNIT - 1 && n <= UNIT + 4, 1);
		operation_on_i = 0;
		cyc(2);
		chk(out_enable_o, 2'b00);
		operation_on_i = 1;
		en_pin_i = 0;
		cyc(3);
		chk(out_enable_o, 2'b00);
		en_pin_i = 1;
		other_fault_i = 1;
		cyc(3);
		chk(out_enable_o, 2'b00);
		other_fault_i = 0;
		cyc(1);
		chk(out_enable_o, 2'b11);
		wr(8'h54, 16'h003f, 0, 0);
		temp_i[15:0] = 16'he4e0;
		cyc(2);
		chk({ut_fault_o[0], out_enable_o[0]}, 2'b11);
		temp_i[15:0] = 16'h0019;
		wr(8'h54, 16'h0080, 0, 0);
		temp_i[15:0] = 16'he4e0;
		cyc(2);
		temp_i[15:0] = 16'h0019;
		cyc(300);
		chk({out_enable_o, ut_fault_o[0]}, 3'b101);
		$display("response tests done");
		end_of_test();
	end
endmodule // tb
`default_nettype wire
